// *** hdl/dts_channel3.sv ***
// Channel 3 trigger selection register and two-cycle bus sequencer.
// Assumes an Avalon-MM master on the register side and a simple
// ready-paced memory port towards peripheral I/O and internal RAM.
//
// What this block does
// - Trigger register accepts byte and bit accesses.
// - Bits 2..0 select one of eight sources.
// - Hardware sets pending flag on selected trigger.
// - Hardware sets overflow flag on request overflow.
// - Writing zero clears a flag; one leaves it.
// - Triggers during standby never start a transfer.
// - Eight sequencer states; idle issues no access.
// - Ready follows a request plus granted bus.
// - Read open always leads to read final.
// - Read final samples data, then write open.
// - On-chip ready phase waits for memory ready, then write open.
// - Write open always leads to write final.
// - Write strobe low in last write final.
// - Completion pulses done, then returns to idle.
// - Bus released after every finished transfer.
// - Single mode: one unit per request until terminal.
// - Higher channel served first while bus released.
// - Read source address, then write destination.
// - Fixed priority, evaluated only in idle.
// - Start only when enabled and count not done.
// - Terminal count pulses one clock, last cycle.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
module dts_channel3 #(
  parameter int          DATA_W      = 32,
  parameter int          CNT_W       = 16,
  parameter logic [31:0] ONCHIP_BASE = 32'hffff0000,
  parameter logic [31:0] ONCHIP_LAST = 32'hffffffff
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic [31:0]       avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic [7:0]        periph_irq_in,
  input  wire logic              standby_in,
  input  wire logic [2:0]        higher_req_in,
  output logic                   bus_req_out,
  input  wire logic              bus_grant_in,
  output logic      [31:0]       mem_addr_out,
  output logic                   mem_rd_out,
  output logic                   mem_wr_out,
  output logic      [DATA_W-1:0] mem_wdata_out,
  input  wire logic [DATA_W-1:0] mem_rdata_in,
  input  wire logic              mem_ready_in,
  output logic                   tc_out,
  output logic                   xfer_done_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dts_pkg::dts_state_t state;
  dts_pkg::dts_state_t next_state;
  logic             ack;
  logic             pend;
  logic             ovf;
  logic             fix5;
  logic [2:0]       src_sel;
  logic             enable;
  logic             done;
  logic [31:0]      src_addr;
  logic [31:0]      dst_addr;
  logic [CNT_W-1:0] remain;
  logic             acc;
  logic             wr_go;
  logic             wr_trig;
  logic             wr_bit;
  logic             wr_ctrl;
  logic             hit;
  logic             consume;
  logic             start_ok;
  logic             last_write;
  logic             clr_pend;
  logic             clr_ovf;
  logic             next_pend;
  logic             next_ovf;
  logic [7:0]       trig_byte;

  function automatic logic idx_hit(input logic [31:0] a, input logic [31:0] idx);
    idx_hit = (a == idx);
  endfunction : idx_hit

  function automatic logic is_onchip(input logic [31:0] a);
    is_onchip = (a >= ONCHIP_BASE) && (a <= ONCHIP_LAST);
  endfunction : is_onchip

  // ----------------------------------------------------------------
  // Avalon-MM slave: every access waits exactly one cycle
  // ----------------------------------------------------------------
  assign acc                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = acc & ~ack;
  assign wr_go               = avs_write_in & ack;
  assign wr_trig             = wr_go & idx_hit(avs_address_in, dts_pkg::TRIG_IDX) & avs_byteenable_in[0];
  assign wr_bit              = wr_go & idx_hit(avs_address_in, dts_pkg::BIT_IDX) & avs_byteenable_in[0];
  assign wr_ctrl             = wr_go & idx_hit(avs_address_in, dts_pkg::CTRL_IDX) & avs_byteenable_in[0];
  assign trig_byte           = {pend, ovf, fix5, 2'h0, src_sel};

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= acc & ~ack;
    end
  end

  // Read data is captured in the wait cycle so it stands at the release edge.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= dts_pkg::RD_UNMAP;
    end else if (avs_read_in && !ack) begin
      if (idx_hit(avs_address_in, dts_pkg::TRIG_IDX) || idx_hit(avs_address_in, dts_pkg::BIT_IDX)) begin
        avs_readdata_out <= {24'h000000, trig_byte};
      end else if (idx_hit(avs_address_in, dts_pkg::CTRL_IDX)) begin
        avs_readdata_out <= {30'h00000000, done, enable};
      end else if (idx_hit(avs_address_in, dts_pkg::SRC_IDX)) begin
        avs_readdata_out <= src_addr;
      end else if (idx_hit(avs_address_in, dts_pkg::DST_IDX)) begin
        avs_readdata_out <= dst_addr;
      end else if (idx_hit(avs_address_in, dts_pkg::CNT_IDX)) begin
        avs_readdata_out <= 32'(remain);
      end else if (idx_hit(avs_address_in, dts_pkg::STAT_IDX)) begin
        avs_readdata_out <= {24'h000000, state};
      end else begin
        avs_readdata_out <= dts_pkg::RD_UNMAP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger register: source select and the fixed bit
  // ----------------------------------------------------------------
  // The bit-access port writes one bit: data[2:0] is its position, data[3] its value.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      src_sel <= dts_pkg::TRIG_RST[2:0];
      fix5    <= dts_pkg::TRIG_RST[dts_pkg::FIX_BIT];
    end else if (wr_trig) begin
      src_sel <= avs_writedata_in[2:0];
      fix5    <= avs_writedata_in[dts_pkg::FIX_BIT];
    end else if (wr_bit) begin
      if (avs_writedata_in[2:0] < 3'h3) begin
        src_sel[avs_writedata_in[1:0]] <= avs_writedata_in[dts_pkg::BIT_VAL];
      end else if (avs_writedata_in[2:0] == 3'(dts_pkg::FIX_BIT)) begin
        fix5 <= avs_writedata_in[dts_pkg::BIT_VAL];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending and overflow flags
  // ----------------------------------------------------------------
  assign hit      = periph_irq_in[src_sel] & ~standby_in;
  assign consume  = (state == dts_pkg::IDLE_PHASE) && (next_state == dts_pkg::READY_PHASE);
  assign clr_pend = (wr_trig && !avs_writedata_in[dts_pkg::PEND_BIT]) ||
                    (wr_bit && avs_writedata_in[2:0] == 3'(dts_pkg::PEND_BIT) &&
                     !avs_writedata_in[dts_pkg::BIT_VAL]);
  assign clr_ovf  = (wr_trig && !avs_writedata_in[dts_pkg::OVF_BIT]) ||
                    (wr_bit && avs_writedata_in[2:0] == 3'(dts_pkg::OVF_BIT) &&
                     !avs_writedata_in[dts_pkg::BIT_VAL]);

  // A hardware set always wins over a clear landing in the same cycle.
  always_comb begin
    next_pend = pend;
    next_ovf  = ovf;
    if (clr_pend || consume) begin
      next_pend = 1'b0;
    end
    if (clr_ovf) begin
      next_ovf = 1'b0;
    end
    if (hit) begin
      next_pend = 1'b1;
    end
    if (hit && pend && !consume) begin
      next_ovf = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pend <= dts_pkg::TRIG_RST[dts_pkg::PEND_BIT];
      ovf  <= dts_pkg::TRIG_RST[dts_pkg::OVF_BIT];
    end else begin
      pend <= next_pend;
      ovf  <= next_ovf;
    end
  end

  // ----------------------------------------------------------------
  // Channel control, addresses and count
  // ----------------------------------------------------------------
  assign last_write = (state == dts_pkg::WRITE_FINAL_PHASE) && mem_ready_in;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      enable <= 1'b0;
    end else if (wr_ctrl) begin
      enable <= avs_writedata_in[dts_pkg::EN_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      done <= 1'b0;
    end else if (state == dts_pkg::COMPLETION_PHASE && remain == CNT_W'(0)) begin
      done <= 1'b1;
    end else if (wr_ctrl && !avs_writedata_in[dts_pkg::DONE_BIT]) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      src_addr <= dts_pkg::ADDR_RST;
      dst_addr <= dts_pkg::ADDR_RST;
    end else if (wr_go && idx_hit(avs_address_in, dts_pkg::SRC_IDX)) begin
      src_addr <= avs_writedata_in;
    end else if (wr_go && idx_hit(avs_address_in, dts_pkg::DST_IDX)) begin
      dst_addr <= avs_writedata_in;
    end
  end

  // One unit per request; the count runs down to the terminal count.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      remain <= '0;
    end else if (wr_go && idx_hit(avs_address_in, dts_pkg::CNT_IDX)) begin
      remain <= avs_writedata_in[CNT_W-1:0];
    end else if (last_write && remain != CNT_W'(0)) begin
      remain <= remain - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  // Channel 3 is lowest; any higher request seen in idle keeps it waiting.
  assign start_ok    = pend && enable && !done && (higher_req_in == 3'h0);
  assign bus_req_out = ((state == dts_pkg::IDLE_PHASE) && start_ok) ||
                       ((state != dts_pkg::IDLE_PHASE) && (state != dts_pkg::COMPLETION_PHASE));

  always_comb begin
    next_state = state;
    unique case (state)
      dts_pkg::IDLE_PHASE: begin
        if (start_ok && bus_grant_in) begin
          next_state = dts_pkg::READY_PHASE;
        end
      end
      dts_pkg::READY_PHASE: begin
        next_state = is_onchip(src_addr) ? dts_pkg::ONCHIP_READY_PHASE : dts_pkg::READ_OPEN_PHASE;
      end
      dts_pkg::READ_OPEN_PHASE: begin
        next_state = dts_pkg::READ_FINAL_PHASE;
      end
      dts_pkg::READ_FINAL_PHASE: begin
        if (mem_ready_in) begin
          next_state = dts_pkg::WRITE_OPEN_PHASE;
        end
      end
      dts_pkg::ONCHIP_READY_PHASE: begin
        if (mem_ready_in) begin
          next_state = dts_pkg::WRITE_OPEN_PHASE;
        end
      end
      dts_pkg::WRITE_OPEN_PHASE: begin
        next_state = dts_pkg::WRITE_FINAL_PHASE;
      end
      dts_pkg::WRITE_FINAL_PHASE: begin
        if (mem_ready_in) begin
          next_state = dts_pkg::COMPLETION_PHASE;
        end
      end
      dts_pkg::COMPLETION_PHASE: begin
        next_state = dts_pkg::IDLE_PHASE;
      end
      default: begin
        next_state = dts_pkg::IDLE_PHASE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= dts_pkg::IDLE_PHASE;
    end else begin
      state <= next_state;
    end
  end

  // Source address goes out for the read, destination for the write.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_addr_out <= dts_pkg::ADDR_RST;
    end else if (next_state == dts_pkg::READ_OPEN_PHASE || next_state == dts_pkg::ONCHIP_READY_PHASE) begin
      mem_addr_out <= src_addr;
    end else if (next_state == dts_pkg::WRITE_OPEN_PHASE) begin
      mem_addr_out <= dst_addr;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_wdata_out <= '0;
    end else if ((state == dts_pkg::READ_FINAL_PHASE || state == dts_pkg::ONCHIP_READY_PHASE) && mem_ready_in) begin
      mem_wdata_out <= mem_rdata_in;
    end
  end

  // The write strobe drops in the final write cycle so the target sees a clean end.
  assign mem_rd_out    = (state == dts_pkg::READ_OPEN_PHASE) || (state == dts_pkg::READ_FINAL_PHASE) ||
                         (state == dts_pkg::ONCHIP_READY_PHASE);
  assign mem_wr_out    = (state == dts_pkg::WRITE_OPEN_PHASE) ||
                         ((state == dts_pkg::WRITE_FINAL_PHASE) && !mem_ready_in);
  assign tc_out        = last_write && (remain == CNT_W'(1));
  assign xfer_done_out = (state == dts_pkg::COMPLETION_PHASE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  read_open_seq_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state == dts_pkg::READ_OPEN_PHASE |=> state == dts_pkg::READ_FINAL_PHASE && mem_rd_out)
    else $error("read open not followed by read final");

  read_final_seq_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == dts_pkg::READ_FINAL_PHASE && mem_ready_in) |=>
      state == dts_pkg::WRITE_OPEN_PHASE && mem_wdata_out == $past(mem_rdata_in))
    else $error("read data not captured before write open");

  write_path_seq_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state == dts_pkg::WRITE_OPEN_PHASE |=> state == dts_pkg::WRITE_FINAL_PHASE && mem_addr_out == $past(dst_addr))
    else $error("write open not followed by write final");

  write_strobe_end_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == dts_pkg::WRITE_FINAL_PHASE && mem_ready_in) |-> !mem_wr_out ##1 state == dts_pkg::COMPLETION_PHASE)
    else $error("write strobe active in last write cycle");

  completion_idle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state == dts_pkg::COMPLETION_PHASE |-> xfer_done_out && !bus_req_out ##1 state == dts_pkg::IDLE_PHASE)
    else $error("completion did not release bus and return to idle");

  idle_no_access_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state == dts_pkg::IDLE_PHASE |-> !mem_rd_out && !mem_wr_out)
    else $error("access issued in idle");

  higher_wins_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == dts_pkg::IDLE_PHASE && higher_req_in != 3'h0) |=> state == dts_pkg::IDLE_PHASE)
    else $error("lower channel started over a higher request");

  start_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(state == dts_pkg::READY_PHASE) |-> $past(enable) && !$past(done) && $past(bus_grant_in) && $past(pend))
    else $error("transfer started without enable, grant or request");

  standby_block_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!pend && standby_in && !(wr_bit && avs_writedata_in[2:0] == 3'h7)) |=> !pend)
    else $error("pending flag set during standby");

  overflow_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (hit && pend && !consume) |=> ovf && pend)
    else $error("overflow not flagged on repeated trigger");

  sw_no_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wr_trig && avs_writedata_in[7:6] == 2'h3 && !ovf && !pend && !hit) |=> !ovf && !pend)
    else $error("software write of one set a flag");

  tc_single_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tc_out |-> last_write ##1 !tc_out ##1 done)
    else $error("terminal count not a single clock in last cycle");

endmodule : dts_channel3

// *** inc/dts_pkg.sv ***
// Shared constants for the channel 3 trigger and bus sequencer.
// Assumes word-addressed Avalon-MM access with 32-bit data.
package dts_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] TRIG_IDX   = 32'hfffff816;
  localparam logic [31:0] BIT_IDX    = 32'h00000100;
  localparam logic [31:0] CTRL_IDX   = 32'h00000101;
  localparam logic [31:0] SRC_IDX    = 32'h00000102;
  localparam logic [31:0] DST_IDX    = 32'h00000103;
  localparam logic [31:0] CNT_IDX    = 32'h00000104;
  localparam logic [31:0] STAT_IDX   = 32'h00000105;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          PEND_BIT   = 7;
  localparam int          OVF_BIT    = 6;
  localparam int          FIX_BIT    = 5;
  localparam int          SEL_LSB    = 0;
  localparam int          SEL_W      = 3;
  localparam int          EN_BIT     = 0;
  localparam int          DONE_BIT   = 1;
  localparam int          BIT_VAL    = 3;
  localparam logic [7:0]  TRIG_RST   = 8'h00;
  localparam logic [31:0] ADDR_RST   = 32'h00000000;
  localparam logic [31:0] RD_UNMAP   = 32'h00000000;

  // ----------------------------------------------------------------
  // Trigger source codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  SRC_SERIAL_PORT_A   = 3'h0;
  localparam logic [2:0]  SRC_SERIAL_PORT_B   = 3'h1;
  localparam logic [2:0]  SRC_SERIAL_PORT_C   = 3'h2;
  localparam logic [2:0]  SRC_ASYNC_PORT_A_TX = 3'h3;
  localparam logic [2:0]  SRC_ASYNC_PORT_B_TX = 3'h4;
  localparam logic [2:0]  SRC_ADC_END         = 3'h5;
  localparam logic [2:0]  SRC_GENERAL_TIMER_A = 3'h6;
  localparam logic [2:0]  SRC_COMPARE_TIMER_B = 3'h7;

  // ----------------------------------------------------------------
  // Bus sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    IDLE_PHASE         = 8'h01,
    READY_PHASE        = 8'h02,
    READ_OPEN_PHASE    = 8'h04,
    READ_FINAL_PHASE   = 8'h08,
    ONCHIP_READY_PHASE = 8'h10,
    WRITE_OPEN_PHASE   = 8'h20,
    WRITE_FINAL_PHASE  = 8'h40,
    COMPLETION_PHASE   = 8'h80
  } dts_state_t;

endpackage : dts_pkg

// *** test/dts_mem_model.sv ***
// Behavioural memory standing for peripheral I/O and internal RAM.
// Assumes the channel drives a ready-paced read/write port.
`timescale 1ns/100ps
module dts_mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        slow_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic        mem_rd_in,
  input  wire logic        mem_wr_in,
  input  wire logic [31:0] mem_wdata_in,
  output logic      [31:0] mem_rdata_out,
  output logic             mem_ready_out,
  output logic      [31:0] last_waddr_out,
  output logic      [31:0] last_wdata_out
);
  logic [3:0]  pace;
  logic [31:0] last_rd;
  // A slow memory inserts a wait state every other cycle.
  assign mem_ready_out = ~slow_in | pace[0];
  // Outside a read the data lines carry no stale value, only its inverse.
  assign mem_rdata_out = mem_rd_in ? (mem_addr_in ^ 32'h5a5a0000) : ~last_rd;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pace           <= 4'h0;
      last_rd        <= 32'h00000000;
      last_waddr_out <= 32'h00000000;
      last_wdata_out <= 32'h00000000;
    end else begin
      pace <= pace + 4'h1;
      if (mem_rd_in) begin
        last_rd <= mem_rdata_out;
      end
      if (mem_wr_in) begin
        last_waddr_out <= mem_addr_in;
        last_wdata_out <= mem_wdata_in;
      end
    end
  end
endmodule : dts_mem_model

// *** test/dts_channel3_bench.sv ***
// Self-checking bench for the channel 3 trigger register and sequencer.
// Assumes the design answers Avalon-MM accesses and a memory model.
`timescale 1ns/100ps
module dts_channel3_bench;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, stby = 1'b0, grant = 1'b0, slow = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, maddr, mwdata, mrdata, waddr_seen, wdata_seen, got;
  logic [7:0]  irq = 8'h00;
  logic [2:0]  hreq = 3'h0;
  logic waitreq, breq, mrd, mwr, mready, tc, done;
  int err_count = 0, samples_checked = 0, tc_seen = 0, done_seen = 0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    grant <= breq;
    if (tc === 1'b1) tc_seen++;
    if (done === 1'b1) done_seen++;
  end
  dts_channel3 dut (.clk_sys_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .periph_irq_in(irq), .standby_in(stby), .higher_req_in(hreq),
    .bus_req_out(breq), .bus_grant_in(grant), .mem_addr_out(maddr), .mem_rd_out(mrd), .mem_wr_out(mwr),
    .mem_wdata_out(mwdata), .mem_rdata_in(mrdata), .mem_ready_in(mready), .tc_out(tc), .xfer_done_out(done));
  dts_mem_model mem (.clk_sys_in(clk), .rst_in(rst), .slow_in(slow), .mem_addr_in(maddr), .mem_rd_in(mrd),
    .mem_wr_in(mwr), .mem_wdata_in(mwdata), .mem_rdata_out(mrdata), .mem_ready_out(mready),
    .last_waddr_out(waddr_seen), .last_wdata_out(wdata_seen));
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic av_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    // The request stands until the rising edge at which waitrequest is seen low.
    forever begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    wr <= 1'b0;
  endtask : av_write
  task automatic av_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    forever begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    d = rdata;
    rd <= 1'b0;
  endtask : av_read
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic check_reg(input logic [31:0] a, input logic [31:0] e);
    av_read(a, got);
    check(got, e);
  endtask : check_reg
  task automatic pulse(input int code);
    @(posedge clk);
    irq <= 8'h01 << code;
    @(posedge clk);
    irq <= 8'h00;
  endtask : pulse
  task automatic wait_done(input int n);
    for (int i = 0; i < 200 && done_seen < n; i++) @(posedge clk);
    check(done_seen, n);
  endtask : wait_done
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check_reg(dts_pkg::TRIG_IDX, 32'h00);
    check_reg(32'h00000200, dts_pkg::RD_UNMAP);
    av_write(dts_pkg::TRIG_IDX, 32'he5);
    check_reg(dts_pkg::TRIG_IDX, 32'h25);
    av_write(dts_pkg::BIT_IDX, 32'h9);
    check_reg(dts_pkg::TRIG_IDX, 32'h27);
    for (int c = 0; c < 8; c++) begin
      av_write(dts_pkg::TRIG_IDX, 32'h20 | c);
      pulse((c + 1) % 8);
      check_reg(dts_pkg::TRIG_IDX, 32'h20 | c);
      pulse(c);
      check_reg(dts_pkg::TRIG_IDX, 32'ha0 | c);
      av_write(dts_pkg::TRIG_IDX, 32'h20 | c);
      check_reg(dts_pkg::TRIG_IDX, 32'h20 | c);
    end
    av_write(dts_pkg::TRIG_IDX, 32'h20);
    stby <= 1'b1;
    pulse(0);
    stby <= 1'b0;
    check_reg(dts_pkg::TRIG_IDX, 32'h20);
    pulse(0);
    pulse(0);
    check_reg(dts_pkg::TRIG_IDX, 32'he0);
    av_write(dts_pkg::TRIG_IDX, 32'h60);
    check_reg(dts_pkg::TRIG_IDX, 32'h60);
    av_write(dts_pkg::TRIG_IDX, 32'h20);
    // Endpoints stay clear of the on-chip address range.
    av_write(dts_pkg::SRC_IDX, 32'h1000);
    av_write(dts_pkg::DST_IDX, 32'h2000);
    av_write(dts_pkg::CNT_IDX, 32'h2);
    av_write(dts_pkg::CTRL_IDX, 32'h1);
    pulse(0);
    wait_done(1);
    check(waddr_seen, 32'h2000);
    check(wdata_seen, 32'h1000 ^ 32'h5a5a0000);
    check(tc_seen, 0);
    check(breq, 1'b0);
    check_reg(dts_pkg::STAT_IDX, 32'h01);
    check_reg(dts_pkg::TRIG_IDX, 32'h20);
    slow <= 1'b1;
    av_write(dts_pkg::SRC_IDX, 32'hffff0010);
    pulse(0);
    wait_done(2);
    check(wdata_seen, 32'hffff0010 ^ 32'h5a5a0000);
    check(tc_seen, 1);
    check_reg(dts_pkg::CTRL_IDX, 32'h3);
    pulse(0);
    repeat (20) @(posedge clk);
    check(done_seen, 2);
    av_write(dts_pkg::TRIG_IDX, 32'h20);
    av_write(dts_pkg::CNT_IDX, 32'h1);
    av_write(dts_pkg::CTRL_IDX, 32'h1);
    hreq <= 3'h4;
    pulse(0);
    repeat (20) @(posedge clk);
    check(breq, 1'b0);
    check(done_seen, 2);
    hreq <= 3'h0;
    wait_done(3);
    check(tc_seen, 2);
    tally_and_finish();
  end
endmodule : dts_channel3_bench
